// *** shared/mrac_map.svh ***
// Notes on behaviour
// - hardware reset honoured only in normal mode
// - hardware reset defaults every register, lock included
// - transition end: irq low, done flag set
// - writing done bit one clears flag, irq
// - processor idle after any reset until started
// - hardware reset selects I2C port
// - setup bit 7 starts soft reset
// - soft reset keeps lock and threshold registers
// - soft reset keeps locked port choice
// - soft reset end clears bit, flags done
// - soft reset ignored outside normal mode
// - phase gain field bits 2 to 0
// - neutral gain field bits 5 to 3
// - voltage gain field bits 8 to 6
// - converter power per mode
// - modulator clock is master clock over 16
// - decimator averages bitstream into 24-bit words
// - done interrupt unmaskable until flag cleared
`ifndef MRAC_MAP_SVH
`define MRAC_MAP_SVH
`define MRAC_DONE_BIT        15
`define MRAC_SOFT_RST_BIT    7
`define MRAC_I2C_LOCK_BIT    1
`define MRAC_RUN_START       16'h0001
`define MRAC_RUN_STOP        16'h0000
`define MRAC_PHASE_LSB       0
`define MRAC_NEUTRAL_LSB     3
`define MRAC_VOLTAGE_LSB     6
`define MRAC_GAIN_MAX_CODE   3'h4
`define MRAC_GAIN_RST        9'h000
`define MRAC_SETUP_RST       16'h0000
`define MRAC_LOCK_RST        16'h0000
`define MRAC_THR_RST         16'h0000
`define MRAC_RUN_RST         16'h0000
`define MRAC_CLK_NS          25
`define MRAC_RST_MIN_NS      10000
`define MRAC_RST_MIN_CYC ((`MRAC_RST_MIN_NS + `MRAC_CLK_NS - 1) / `MRAC_CLK_NS)
`define MRAC_MOD_DIV         16
`define MRAC_TRANS_CYC       64
`define MRAC_SPI_FALLS       3
`define MRAC_OSR             128
`endif

// *** shared/mrac_pkg.sv ***
package mrac_pkg;
   typedef enum logic [1:0]
   {
      normal_power_mode,
      reduced_power_mode,
      low_power_mode,
      sleep_power_mode
   } mrac_pmode_e;

   typedef enum logic [1:0]
   {
      ST_RUN,
      ST_PIN_LOW,
      ST_TRANS
   } mrac_state_e;

   // gain register fields, msb first as they sit in the register
   typedef struct packed
   {
      logic [2:0] voltage;
      logic [2:0] neutral;
      logic [2:0] phase;
   } mrac_gain_s;

   // converter enables: three phase currents, neutral, three voltages
   typedef struct packed
   {
      logic [2:0] volt;
      logic       neutral;
      logic [2:0] phase;
   } mrac_adc_en_s;
endpackage

// *** src/mrac_clkdiv.sv ***
`timescale 1ns/1ps
`include "mrac_map.svh"
module mrac_clkdiv
#(
   parameter int DIV = `MRAC_MOD_DIV
)
(
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   output logic      strobe_out
);
   logic [$clog2(DIV)-1:0] cnt_q;
   logic [$clog2(DIV)-1:0] cnt_d;
   logic                   stb_q;
   logic                   stb_d;

   // one-cycle strobe per modulator sample; a strobe avoids a derived clock
   always_comb
   begin
      stb_d = (cnt_q == $clog2(DIV)'(DIV - 1));
      cnt_d = stb_d ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cnt_q <= '0;
         stb_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         stb_q <= stb_d;
      end
   end

   assign strobe_out = stb_q;
endmodule // mrac_clkdiv

// *** src/mrac_decim.sv ***
`timescale 1ns/1ps
`include "mrac_map.svh"
module mrac_decim
#(
   parameter int OSR = `MRAC_OSR
)
(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        enable_in,
   input  wire logic        sample_in,
   input  wire logic        bit_in,
   output logic [23:0]      word_out,
   output logic             valid_out
);
   localparam int CW = $clog2(OSR) + 1;
   localparam int SH = 25 - CW;

   logic [CW-1:0] ones_q;
   logic [CW-1:0] ones_d;
   logic [CW-1:0] n_q;
   logic [CW-1:0] n_d;
   logic [23:0]   word_q;
   logic [23:0]   word_d;
   logic          vld_d;
   logic          vld_q;
   logic [CW-1:0] ones_now;
   logic [CW:0]   diff;
   logic [24:0]   wide;

   // boxcar average of OSR modulator bits, centred and scaled to 24 bits
   always_comb
   begin
      ones_now = ones_q + CW'(bit_in);
      diff     = {1'b0, ones_now} - (CW + 1)'(OSR / 2);
      wide     = 25'($signed(diff)) <<< SH;
      ones_d   = ones_q;
      n_d      = n_q;
      word_d   = word_q;
      vld_d    = 1'b0;
      if (!enable_in)
      begin
         ones_d = '0;
         n_d    = '0;
      end
      else if (sample_in)
      begin
         if (n_q == CW'(OSR - 1))
         begin
            // full scale count overflows by one lsb, so saturate
            if (!wide[24] && wide[23])
               word_d = 24'h7fffff;
            else
               word_d = wide[23:0];
            vld_d  = 1'b1;
            ones_d = '0;
            n_d    = '0;
         end
         else
         begin
            ones_d = ones_now;
            n_d    = n_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ones_q <= '0;
         n_q    <= '0;
         word_q <= 24'h000000;
         vld_q  <= 1'b0;
      end
      else
      begin
         ones_q <= ones_d;
         n_q    <= n_d;
         word_q <= word_d;
         vld_q  <= vld_d;
      end
   end

   assign word_out  = word_q;
   assign valid_out = vld_q;
endmodule // mrac_decim

// *** src/mrac_top.sv ***
`timescale 1ns/1ps
`include "mrac_map.svh"
module mrac_top
#(
   parameter int TRANS_CYC = `MRAC_TRANS_CYC,
   parameter int OSR       = `MRAC_OSR
)
(
   input  wire logic                  clk_in,
   input  wire logic                  arst_n_in,
   input  wire logic                  reset_pin_n_in,
   input  wire mrac_pkg::mrac_pmode_e power_mode_in,
   input  wire logic                  slave_select_pin_n_in,
   input  wire logic                  setup_wr_in,
   input  wire logic [15:0]           setup_data_in,
   input  wire logic                  status_wr_in,
   input  wire logic [15:0]           status_data_in,
   input  wire logic                  gain_wr_in,
   input  wire mrac_pkg::mrac_gain_s  gain_data_in,
   input  wire logic                  lock_wr_in,
   input  wire logic [15:0]           lock_data_in,
   input  wire logic                  thr_wr_in,
   input  wire logic [15:0]           thr_data_in,
   input  wire logic                  run_wr_in,
   input  wire logic [15:0]           run_data_in,
   input  wire logic [6:0]            mod_bits_in,
   output logic                       secondary_interrupt_pin_n_out,
   output logic                       reset_done_flag_out,
   output logic [15:0]                setup_out,
   output mrac_pkg::mrac_gain_s       gain_out,
   output logic [2:0]                 gain_reserved_out,
   output logic [15:0]                lock_out,
   output logic [15:0]                thr_out,
   output logic [15:0]                run_out,
   output logic                       dsp_running_out,
   output logic                       spi_active_out,
   output logic                       port_locked_out,
   output logic                       in_reset_out,
   output mrac_pkg::mrac_adc_en_s     adc_en_out,
   output logic                       mod_strobe_out,
   output logic [6:0][23:0]           adc_word_out,
   output logic [6:0]                 adc_valid_out
);
   localparam int LW = $clog2(`MRAC_RST_MIN_CYC + 1);
   localparam int TW = $clog2(TRANS_CYC + 1);

   // true when a three-bit gain code is one of the five defined gains
   function automatic logic gain_code_ok(input logic [2:0] code);
      gain_code_ok = (code <= `MRAC_GAIN_MAX_CODE);
   endfunction

   mrac_pkg::mrac_state_e  st_q;
   mrac_pkg::mrac_state_e  st_d;
   logic                   rst_s1_q;
   logic                   rst_s2_q;
   logic [LW-1:0]          low_q;
   logic [LW-1:0]          low_d;
   logic [TW-1:0]          tr_q;
   logic [TW-1:0]          tr_d;
   logic                   hw_trans_q;
   logic                   hw_trans_d;
   logic                   done_q;
   logic                   done_d;
   logic [15:0]            setup_q;
   logic [15:0]            setup_d;
   mrac_pkg::mrac_gain_s   gain_q;
   mrac_pkg::mrac_gain_s   gain_d;
   logic [15:0]            lock_q;
   logic [15:0]            lock_d;
   logic [15:0]            thr_q;
   logic [15:0]            thr_d;
   logic [15:0]            run_q;
   logic [15:0]            run_d;
   logic                   spi_q;
   logic                   spi_d;
   logic                   locked_q;
   logic                   locked_d;
   logic [1:0]             falls_q;
   logic [1:0]             falls_d;
   logic                   ss_prev_q;
   logic                   normal;
   logic                   sw_req;
   logic                   trans_end;
   mrac_pkg::mrac_adc_en_s adc_en;
   logic                   mod_stb;

   // two-flop synchroniser; only the second stage feeds the logic
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_s1_q  <= 1'b1;
         rst_s2_q  <= 1'b1;
         ss_prev_q <= 1'b1;
      end
      else
      begin
         rst_s1_q  <= reset_pin_n_in;
         rst_s2_q  <= rst_s1_q;
         ss_prev_q <= slave_select_pin_n_in;
      end
   end

   assign normal    = (power_mode_in == mrac_pkg::normal_power_mode);
   assign trans_end = (st_q == mrac_pkg::ST_TRANS)
                      && (tr_q == TW'(TRANS_CYC - 1));
   // a low pin owns the sequencer, so a soft request then is dropped
   assign sw_req    = setup_wr_in && setup_data_in[`MRAC_SOFT_RST_BIT]
                      && normal && rst_s2_q
                      && (st_q == mrac_pkg::ST_RUN);

   // reset sequencer: measures the pin low time, runs the transition
   always_comb
   begin
      st_d       = st_q;
      low_d      = low_q;
      tr_d       = tr_q;
      hw_trans_d = hw_trans_q;
      case (st_q)
         mrac_pkg::ST_RUN:
         begin
            low_d = '0;
            tr_d  = '0;
            if (!rst_s2_q && normal)
               st_d = mrac_pkg::ST_PIN_LOW;
            else if (sw_req)
            begin
               st_d       = mrac_pkg::ST_TRANS;
               hw_trans_d = 1'b0;
            end
         end
         mrac_pkg::ST_PIN_LOW:
         begin
            if (low_q != LW'(`MRAC_RST_MIN_CYC))
               low_d = low_q + 1'b1;
            if (rst_s2_q)
            begin
               // a pulse shorter than the minimum is dropped as a glitch
               if (low_q == LW'(`MRAC_RST_MIN_CYC))
               begin
                  st_d       = mrac_pkg::ST_TRANS;
                  hw_trans_d = 1'b1;
               end
               else
                  st_d = mrac_pkg::ST_RUN;
            end
         end
         mrac_pkg::ST_TRANS:
         begin
            tr_d = tr_q + 1'b1;
            if (trans_end)
               st_d = mrac_pkg::ST_RUN;
         end
         default:
            st_d = mrac_pkg::ST_RUN;
      endcase
   end

   // register file with reset defaults applied on entry to the transition
   always_comb
   begin
      setup_d  = setup_q;
      gain_d   = gain_q;
      lock_d   = lock_q;
      thr_d    = thr_q;
      run_d    = run_q;
      done_d   = done_q;
      spi_d    = spi_q;
      locked_d = locked_q;
      falls_d  = falls_q;
      if (st_q == mrac_pkg::ST_TRANS)
      begin
         // writes are not taken while the transition runs
         done_d = trans_end;
         if (trans_end)
            setup_d[`MRAC_SOFT_RST_BIT] = 1'b0;
         if (tr_q == '0)
         begin
            setup_d = (hw_trans_q) ? `MRAC_SETUP_RST
                      : (`MRAC_SETUP_RST | (16'h0001 << `MRAC_SOFT_RST_BIT));
            gain_d  = `MRAC_GAIN_RST;
            run_d   = `MRAC_RUN_RST;
            falls_d = '0;
            if (hw_trans_q)
            begin
               lock_d   = `MRAC_LOCK_RST;
               thr_d    = `MRAC_THR_RST;
               spi_d    = 1'b0;
               locked_d = 1'b0;
            end
            else if (!locked_q)
               spi_d = 1'b0;
         end
      end
      else
      begin
         if (setup_wr_in && !sw_req)
            setup_d = setup_data_in & ~(16'h0001 << `MRAC_SOFT_RST_BIT);
         else if (sw_req)
            setup_d = setup_data_in;
         if (gain_wr_in)
            gain_d = gain_data_in;
         if (thr_wr_in)
            thr_d = thr_data_in;
         if (run_wr_in)
            run_d = run_data_in;
         // flag stays until software clears it or a new transition starts, whatever the masks say
         if (status_wr_in && status_data_in[`MRAC_DONE_BIT])
            done_d = 1'b0;
         if (lock_wr_in)
         begin
            lock_d = lock_data_in;
            if (spi_q || lock_data_in[`MRAC_I2C_LOCK_BIT])
               locked_d = 1'b1;
         end
         // third falling edge on slave select moves to the spi port
         if (!locked_q && !spi_q && ss_prev_q && !slave_select_pin_n_in)
         begin
            if (falls_q == 2'(`MRAC_SPI_FALLS - 1))
            begin
               spi_d   = 1'b1;
               falls_d = '0;
            end
            else
               falls_d = falls_q + 1'b1;
         end
         // a stale flag must not read set while the transition runs
         if (st_d == mrac_pkg::ST_TRANS)
            done_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st_q       <= mrac_pkg::ST_RUN;
         low_q      <= '0;
         tr_q       <= '0;
         hw_trans_q <= 1'b0;
         done_q     <= 1'b0;
         setup_q    <= `MRAC_SETUP_RST;
         gain_q     <= `MRAC_GAIN_RST;
         lock_q     <= `MRAC_LOCK_RST;
         thr_q      <= `MRAC_THR_RST;
         run_q      <= `MRAC_RUN_RST;
         spi_q      <= 1'b0;
         locked_q   <= 1'b0;
         falls_q    <= '0;
      end
      else
      begin
         st_q       <= st_d;
         low_q      <= low_d;
         tr_q       <= tr_d;
         hw_trans_q <= hw_trans_d;
         done_q     <= done_d;
         setup_q    <= setup_d;
         gain_q     <= gain_d;
         lock_q     <= lock_d;
         thr_q      <= thr_d;
         run_q      <= run_d;
         spi_q      <= spi_d;
         locked_q   <= locked_d;
         falls_q    <= falls_d;
      end
   end

   // converter power follows the mode; all off during the transition
   always_comb
   begin
      adc_en = '0;
      if (st_q != mrac_pkg::ST_TRANS)
      begin
         case (power_mode_in)
            mrac_pkg::normal_power_mode:  adc_en = '1;
            mrac_pkg::reduced_power_mode: adc_en.phase = 3'h7;
            default:                      adc_en = '0;
         endcase
      end
   end

   mrac_clkdiv #(
      .DIV (`MRAC_MOD_DIV)
   ) u_div (
      .clk_in     (clk_in),
      .arst_n_in  (arst_n_in),
      .strobe_out (mod_stb)
   );

   // one decimator per converter, gated by its power enable
   for (genvar i = 0; i < 7; i++)
   begin : g_adc
      mrac_decim #(
         .OSR (OSR)
      ) u_dec (
         .clk_in    (clk_in),
         .arst_n_in (arst_n_in),
         .enable_in (adc_en[i]),
         .sample_in (mod_stb),
         .bit_in    (mod_bits_in[i]),
         .word_out  (adc_word_out[i]),
         .valid_out (adc_valid_out[i])
      );
   end

   assign secondary_interrupt_pin_n_out = ~done_q;
   assign reset_done_flag_out = done_q;
   assign setup_out           = setup_q;
   assign gain_out            = gain_q;
   assign gain_reserved_out   = {~gain_code_ok(gain_q.voltage),
                                 ~gain_code_ok(gain_q.neutral),
                                 ~gain_code_ok(gain_q.phase)};
   assign lock_out            = lock_q;
   assign thr_out             = thr_q;
   assign run_out             = run_q;
   // processor runs only after the start word and outside the transition
   assign dsp_running_out     = (run_q == `MRAC_RUN_START)
                                && (st_q != mrac_pkg::ST_TRANS);
   assign spi_active_out      = spi_q;
   assign port_locked_out     = locked_q;
   assign in_reset_out        = (st_q == mrac_pkg::ST_TRANS);
   assign adc_en_out          = adc_en;
   assign mod_strobe_out      = mod_stb;
endmodule // mrac_top

// *** dv/mrac_assertions.sv ***
`timescale 1ns/1ps
module mrac_assertions
(
   input wire logic                   clk_in,
   input wire logic                   arst_n_in,
   input wire logic                   reset_pin_n_in,
   input wire mrac_pkg::mrac_pmode_e  power_mode_in,
   input wire logic                   setup_wr_in,
   input wire logic [15:0]            setup_data_in,
   input wire logic                   status_wr_in,
   input wire logic [15:0]            status_data_in,
   input wire logic                   secondary_interrupt_pin_n_out,
   input wire logic                   reset_done_flag_out,
   input wire logic [15:0]            setup_out,
   input wire mrac_pkg::mrac_gain_s   gain_out,
   input wire logic [2:0]             gain_reserved_out,
   input wire logic [15:0]            lock_out,
   input wire logic [15:0]            thr_out,
   input wire logic [15:0]            run_out,
   input wire logic                   dsp_running_out,
   input wire logic                   in_reset_out,
   input wire mrac_pkg::mrac_adc_en_s adc_en_out,
   input wire logic                   mod_strobe_out
);
   // a soft reset request as seen at the ports, busy state excluded
   wire logic soft_req;
   wire logic normal;
   assign soft_req = setup_wr_in && setup_data_in[7] && !in_reset_out;
   assign normal = power_mode_in == mrac_pkg::normal_power_mode;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   a_irq_follows_flag:
      assert property (secondary_interrupt_pin_n_out == !reset_done_flag_out)
      else $error("irq pin differs from done flag");
   a_done_clear_w1c:
      assert property (status_wr_in && status_data_in[15] && !in_reset_out
         |=> !reset_done_flag_out) else $error("done flag not cleared");
   a_flag_low_busy:
      assert property (in_reset_out |-> !reset_done_flag_out)
      else $error("done flag high during transition");
   a_done_at_end:
      assert property ($fell(in_reset_out) |-> reset_done_flag_out
         && !setup_out[7]) else $error("transition end not flagged");
   // pin must have been high a few clocks, else the width counter owns it
   a_soft_starts:
      assert property (soft_req && normal && reset_pin_n_in
         && $past(reset_pin_n_in, 3) |=> in_reset_out && !reset_done_flag_out)
      else $error("soft reset did not start");
   a_soft_ignored:
      assert property (soft_req && !normal |=> !in_reset_out)
      else $error("soft reset taken outside normal mode");
   a_trans_defaults:
      assert property (in_reset_out && $past(in_reset_out)
         |-> run_out == 16'h0000 && gain_out == 9'h000 && !dsp_running_out
         && adc_en_out == 7'h00)
      else $error("defaults not loaded in transition");
   a_soft_keeps:
      assert property (soft_req && normal && reset_pin_n_in
         && $past(reset_pin_n_in, 3)
         |=> ##1 ($stable(lock_out) && $stable(thr_out)) [*3])
      else $error("lock or threshold lost in soft reset");
   a_adc_power:
      assert property (!in_reset_out |-> adc_en_out == (normal ? 7'h7f :
         power_mode_in == mrac_pkg::reduced_power_mode ? 7'h07 : 7'h00))
      else $error("converter enables wrong for mode");
   a_mod_div16:
      assert property (mod_strobe_out |=> (!mod_strobe_out) [*8] ##8
         mod_strobe_out) else $error("modulator strobe not every 16");
   a_gain_reserved:
      assert property (gain_reserved_out == {gain_out.voltage > 3'h4,
         gain_out.neutral > 3'h4, gain_out.phase > 3'h4})
      else $error("reserved gain flags wrong");
endmodule // mrac_assertions

bind mrac_top mrac_assertions i_chk
(
   .clk_in(clk_in), .arst_n_in(arst_n_in), .reset_pin_n_in(reset_pin_n_in),
   .power_mode_in(power_mode_in), .setup_wr_in(setup_wr_in),
   .setup_data_in(setup_data_in), .status_wr_in(status_wr_in),
   .status_data_in(status_data_in), .reset_done_flag_out(reset_done_flag_out),
   .secondary_interrupt_pin_n_out(secondary_interrupt_pin_n_out),
   .setup_out(setup_out), .gain_out(gain_out), .lock_out(lock_out),
   .gain_reserved_out(gain_reserved_out), .thr_out(thr_out),
   .run_out(run_out), .dsp_running_out(dsp_running_out),
   .in_reset_out(in_reset_out), .adc_en_out(adc_en_out),
   .mod_strobe_out(mod_strobe_out)
);

// *** dv/mrac_host.sv ***
`timescale 1ns/1ps
module mrac_host
(
   input  wire logic clk_in,
   output logic      reset_pin_n_out,
   output logic      slave_select_pin_n_out
);
   // both pins idle high, they are pulled up on the board
   initial
   begin
      reset_pin_n_out = 1'b1;
      slave_select_pin_n_out = 1'b1;
   end

   // hold the reset pin low for a counted number of clocks
   task automatic pulse_reset(input int cyc);
      @(negedge clk_in);
      reset_pin_n_out = 1'b0;
      repeat (cyc) @(negedge clk_in);
      reset_pin_n_out = 1'b1;
   endtask

   // three falls pick spi; repeated after every pin reset
   task automatic select_spi();
      repeat (3)
      begin
         @(negedge clk_in);
         slave_select_pin_n_out = 1'b0;
         repeat (2) @(negedge clk_in);
         slave_select_pin_n_out = 1'b1;
      end
      repeat (4) @(negedge clk_in); // let the synchroniser settle
   endtask
endmodule // mrac_host

// *** dv/mrac_top_test.sv ***
`timescale 1ns/1ps
module mrac_top_test;
   // short transition and decimation keep the run brief
   localparam int TRANS = 4;
   localparam int OSR = 8;
   localparam int SET = 0, STA = 1, GAI = 2, LCK = 3, THR = 4, RUN = 5;
   logic                   clk_in, arst_n_in, rst_pin_n, ss_n;
   mrac_pkg::mrac_pmode_e  mode;
   logic [5:0]             wr;
   logic [15:0]            d, setup, lock, thr, run;
   logic [6:0]             mod_bits, valid;
   logic                   irq_n, flag, dsp, spi, locked, busy, strobe;
   mrac_pkg::mrac_gain_s   gain;
   logic [2:0]             rsv;
   mrac_pkg::mrac_adc_en_s adc_en;
   logic [6:0][23:0]       words;
   int                     miscompares, check_count, cyc;

   mrac_top #(.TRANS_CYC(TRANS), .OSR(OSR)) i_dut
   (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .reset_pin_n_in(rst_pin_n),
      .power_mode_in(mode), .slave_select_pin_n_in(ss_n),
      .setup_wr_in(wr[0]), .setup_data_in(d), .status_wr_in(wr[1]),
      .status_data_in(d), .gain_wr_in(wr[2]), .gain_data_in(d[8:0]),
      .lock_wr_in(wr[3]), .lock_data_in(d), .thr_wr_in(wr[4]),
      .thr_data_in(d), .run_wr_in(wr[5]), .run_data_in(d),
      .mod_bits_in(mod_bits), .secondary_interrupt_pin_n_out(irq_n),
      .reset_done_flag_out(flag), .setup_out(setup), .gain_out(gain),
      .gain_reserved_out(rsv), .lock_out(lock), .thr_out(thr),
      .run_out(run), .dsp_running_out(dsp), .spi_active_out(spi),
      .port_locked_out(locked), .in_reset_out(busy), .adc_en_out(adc_en),
      .mod_strobe_out(strobe), .adc_word_out(words), .adc_valid_out(valid)
   );

   mrac_host i_host
   (
      .clk_in(clk_in), .reset_pin_n_out(rst_pin_n),
      .slave_select_pin_n_out(ss_n)
   );

   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // a hung wait ends the run with a counted failure
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         miscompares++;
         test_done();
      end
   end

   task automatic chk(input string n, input logic [23:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, exp, got);
      end
   endtask

   // one register write: strobe up one clock, shared data bus
   task automatic put(input int r, input logic [15:0] v);
      @(negedge clk_in);
      d = v;
      wr = 6'(1 << r);
      @(negedge clk_in);
      wr = 6'h00;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (flag !== 1'b1 && n < 600)
      begin
         @(negedge clk_in);
         n++;
      end
      chk("done flag", flag, 1'b1);
      chk("irq pin", irq_n, 1'b0);
   endtask

   task automatic clr();
      put(STA, 16'h8000);
      chk("flag cleared", flag, 1'b0);
      chk("irq released", irq_n, 1'b1);
   endtask

   task automatic wait_word();
      int n;
      n = 0;
      do
      begin
         @(negedge clk_in);
         n++;
      end
      while (valid[0] !== 1'b1 && n < 400);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      arst_n_in = 1'b0;
      mode = mrac_pkg::normal_power_mode;
      wr = 6'h00;
      d = 16'h0000;
      mod_bits = 7'h00;
      miscompares = 0;
      check_count = 0;
      idle(10);
      arst_n_in = 1'b1;
      idle(1);
      chk("irq idle", irq_n, 1'b1);
      chk("setup", setup, 16'h0000);
      chk("spi", spi, 1'b0);
      $display("test reset done");
      // every mode, ending in normal
      for (int m = 3; m >= 0; m--)
      begin
         mode = mrac_pkg::mrac_pmode_e'(m);
         idle(1);
         chk("adc", adc_en, m ? (m == 1 ? 7'h07 : 7'h00) : 7'h7f);
      end
      // all eight codes in each field, neutral kept distinct from voltage and phase
      for (int c = 0; c < 8; c++)
      begin
         put(GAI, {7'h00, 3'(c), 3'(7 - c), 3'(c)});
         chk("gain", gain, {3'(c), 3'(7 - c), 3'(c)});
         chk("reserved", rsv, {c > 4, 7 - c > 4, c > 4});
      end
      $display("test modes and gains done");
      put(SET, 16'h0041);
      chk("setup bits", setup, 16'h0041);
      put(LCK, 16'h0002);
      put(THR, 16'h1234);
      put(RUN, 16'h0001);
      chk("dsp running", dsp, 1'b1);
      put(SET, 16'h0080);
      chk("busy", busy, 1'b1);
      chk("flag in transition", flag, 1'b0);
      wait_done();
      chk("soft bit", setup, 16'h0000);
      chk("lock kept", lock, 16'h0002);
      chk("thr kept", thr, 16'h1234);
      chk("run", run, 16'h0000);
      chk("dsp idle", dsp, 1'b0);
      put(STA, 16'h7fff);
      chk("flag held", flag, 1'b1);
      clr();
      i_host.select_spi();
      chk("locked i2c", spi, 1'b0);
      chk("lock state", locked, 1'b1);
      for (int m = 1; m < 4; m++)
      begin
         mode = mrac_pkg::mrac_pmode_e'(m);
         put(SET, 16'h0080);
         idle(TRANS + 2);
         chk("soft ignored", {busy, flag}, 2'b00);
      end
      $display("test soft reset done");
      mode = mrac_pkg::reduced_power_mode;
      i_host.pulse_reset(450);
      idle(TRANS + 4);
      chk("pin ignored", lock, 16'h0002);
      mode = mrac_pkg::normal_power_mode;
      i_host.pulse_reset(100);
      idle(TRANS + 4);
      chk("short pin", {flag, lock}, 17'h00002);
      put(GAI, 16'h00a1);
      i_host.pulse_reset(420);
      wait_done();
      chk("lock cleared", lock, 16'h0000);
      chk("thr cleared", thr, 16'h0000);
      chk("gain cleared", gain, 9'h000);
      chk("i2c default", {spi, locked}, 2'b00);
      chk("dsp after pin", dsp, 1'b0);
      clr();
      i_host.select_spi();
      chk("spi chosen", spi, 1'b1);
      put(LCK, 16'h0000);
      chk("spi locked", locked, 1'b1);
      put(SET, 16'h0080);
      wait_done();
      chk("spi kept", spi, 1'b1);
      clr();
      $display("test pin reset done");
      // channels 0..3 all ones, 4..6 all zeros; third word is whole
      mod_bits = 7'h0f;
      repeat (3) wait_word();
      chk("word ones", words[0], 24'h7fffff);
      chk("neutral ones", words[3], 24'h7fffff);
      chk("volt zeros", words[4], 24'h800000);
      chk("word zeros", words[6], 24'h800000);
      $display("test decimator done");
      test_done();
   end
endmodule // mrac_top_test
